// ### hdl/rmcg_defines.vh
// Register map, field positions and reset values of the run-mode clock gating block.
`ifndef RMCG_DEFINES_VH
`define RMCG_DEFINES_VH
`define RMCG_OFF_RUN_GATE   12'h100
`define RMCG_OFF_SLEEP_GATE 12'h110
`define RMCG_OFF_DEEP_GATE  12'h120
`define RMCG_OFF_MODE_CTRL  12'h060
`define RMCG_RUN_RESET      32'h00000040
`define RMCG_SLEEP_RESET    32'h00000040
`define RMCG_DEEP_RESET     32'h00000040
`define RMCG_CTRL_RESET     32'h00000000
`define RMCG_IMPL_MASK      32'h00000348
`define RMCG_BIT_WATCHDOG0_CLOCK_GATE       3
`define RMCG_BIT_LPD        6
`define RMCG_RATE_LO        8
`define RMCG_RATE_HI        9
`define RMCG_BIT_ACG        0
`define RMCG_BIT_MAXRATE_LO 1
`define RMCG_BIT_MAXRATE_HI 2
`define RMCG_MODE_RUN       2'h0
`define RMCG_MODE_SLEEP     2'h1
`define RMCG_MODE_DEEP      2'h2
`define RMCG_NUM_GATES      2
`define RMCG_ZERO32         32'h00000000
`define RMCG_CTRL_MASK      32'h00000007
`define RMCG_SEL_WATCHDOG0_CLOCK_GATE       2'h1
`define RMCG_SEL_LPD        2'h2
`define RMCG_RATE_RESET     2'h0
`endif

// ### hdl/rmcg_gate_sync.v
// Glitch-free enable stage for one module clock gate.
`timescale 1ns/1ps
module rmcg_gate_sync #(
  parameter [0:0] RESET_ON = 1'b0
) (
  pclk,
  presetn,
  want_on,
  enable_q
);
  input  wire pclk;
  input  wire presetn;
  input  wire want_on;
  output reg  enable_q;
  reg         stage_q;

  // Enable changes only on the clock edge, so a latch-free gate sees no runt pulse.
  always @(negedge presetn or posedge pclk) begin
    if (!presetn) begin
      stage_q  <= RESET_ON;
      enable_q <= RESET_ON;
    end else begin
      stage_q  <= want_on;
      enable_q <= stage_q;
    end
  end
endmodule

// ### hdl/rmcg_top.v
// Run-mode clock gating register block with APB slave and module enables.
//
// Contract
// - A set gating bit enables its module clock and a clear bit leaves the module unclocked.
// - An access to a module whose clock is off is answered with a bus fault.
// - All gating bits reset clear except those given another reset value.
// - Bit 6 gates the low-power domain module and resets to one, giving reset value 0x00000040.
// - Bit 3 is a read-write gate for watchdog 0 and resets to zero.
// - Bits 9:8 select the converter sample rate from 125K at 0x0 up to 1M at 0x3, reset 0x0, capped at the maximum rate in mode control bits 2:1.
// - Reserved bits 7, 5:4 and 2:0 are read-only zero and writes to them are ignored.
// - The run-mode register governs gating in run mode, and in every mode while automatic gating is clear.
// - With automatic gating set, the sleep registers govern gating in sleep modes.
`timescale 1ns/1ps
`include "rmcg_defines.vh"
module rmcg_top (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  power_mode,
  periph_sel,
  periph_access,
  lp_domain_clk_en,
  watchdog0_clock_gate_clk_en,
  converter_sample_rate,
  periph_fault
);
  input  wire        pclk;
  input  wire        presetn;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [11:0] paddr;
  input  wire [31:0] pwdata;
  output reg  [31:0] prdata;
  output reg         pready;
  output reg         pslverr;
  input  wire [1:0]  power_mode;
  input  wire [1:0]  periph_sel;
  input  wire        periph_access;
  output wire        lp_domain_clk_en;
  output wire        watchdog0_clock_gate_clk_en;
  output reg  [1:0]  converter_sample_rate;
  output reg         periph_fault;

  // ==========================================================
  // Registers
  localparam [31:0] RUN_RESET = `RMCG_RUN_RESET;

  reg  [31:0] run_mode_clock_gate_0_q;
  reg  [31:0] sleep_mode_clock_gate_0_q;
  reg  [31:0] deep_sleep_clock_gate_0_q;
  reg  [31:0] run_clock_configuration_q;
  reg  [31:0] run_mode_clock_gate_0_d;
  reg  [31:0] sleep_mode_clock_gate_0_d;
  reg  [31:0] deep_sleep_clock_gate_0_d;
  reg  [31:0] run_clock_configuration_d;
  reg  [31:0] rdata_d;
  reg         hit_d;
  reg  [31:0] prdata_d;
  reg         pready_d;
  reg         pslverr_d;
  reg  [31:0] active_gate_d;
  reg  [1:0]  converter_sample_rate_d;
  reg         periph_fault_d;
  wire [1:0]  max_rate;
  wire [1:0]  rate_field;
  wire        auto_clock_gating;
  wire        access_wait;
  wire        wr_en;
  wire [31:0] wmask;
  wire        want_lpd;
  wire        want_watchdog0_clock_gate;
  wire        watchdog0_clock_gate_selected;
  wire        lpd_selected;
  wire        watchdog0_clock_gate_off;
  wire        lpd_off;

  assign access_wait       = psel & penable & ~pready;
  assign wr_en             = psel & penable & pwrite & pready;
  assign wmask             = pwdata & `RMCG_IMPL_MASK;
  assign max_rate          = run_clock_configuration_q[`RMCG_BIT_MAXRATE_HI:`RMCG_BIT_MAXRATE_LO];
  assign rate_field        = run_mode_clock_gate_0_q[`RMCG_RATE_HI:`RMCG_RATE_LO];
  assign auto_clock_gating = run_clock_configuration_q[`RMCG_BIT_ACG];

  // ==========================================================
  // Register write decode
  always @* begin
    run_mode_clock_gate_0_d   = run_mode_clock_gate_0_q;
    sleep_mode_clock_gate_0_d = sleep_mode_clock_gate_0_q;
    deep_sleep_clock_gate_0_d = deep_sleep_clock_gate_0_q;
    run_clock_configuration_d = run_clock_configuration_q;
    if (wr_en) begin
      case (paddr)
        `RMCG_OFF_RUN_GATE:   run_mode_clock_gate_0_d   = wmask;
        `RMCG_OFF_SLEEP_GATE: sleep_mode_clock_gate_0_d = wmask;
        `RMCG_OFF_DEEP_GATE:  deep_sleep_clock_gate_0_d = wmask;
        `RMCG_OFF_MODE_CTRL:  run_clock_configuration_d = pwdata & `RMCG_CTRL_MASK;
        default: begin
        end
      endcase
    end
  end

  always @(negedge presetn or posedge pclk) begin
    if (!presetn) begin
      run_mode_clock_gate_0_q   <= `RMCG_RUN_RESET;
      sleep_mode_clock_gate_0_q <= `RMCG_SLEEP_RESET;
      deep_sleep_clock_gate_0_q <= `RMCG_DEEP_RESET;
      run_clock_configuration_q <= `RMCG_CTRL_RESET;
    end else begin
      run_mode_clock_gate_0_q   <= run_mode_clock_gate_0_d;
      sleep_mode_clock_gate_0_q <= sleep_mode_clock_gate_0_d;
      deep_sleep_clock_gate_0_q <= deep_sleep_clock_gate_0_d;
      run_clock_configuration_q <= run_clock_configuration_d;
    end
  end

  // ==========================================================
  // APB read decode
  always @* begin
    rdata_d = `RMCG_ZERO32;
    hit_d   = 1'b1;
    case (paddr)
      `RMCG_OFF_RUN_GATE:   rdata_d = run_mode_clock_gate_0_q;
      `RMCG_OFF_SLEEP_GATE: rdata_d = sleep_mode_clock_gate_0_q;
      `RMCG_OFF_DEEP_GATE:  rdata_d = deep_sleep_clock_gate_0_q;
      `RMCG_OFF_MODE_CTRL:  rdata_d = run_clock_configuration_q;
      default:              hit_d   = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always @* begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = `RMCG_ZERO32;
    if (access_wait) begin
      pready_d  = 1'b1;
      pslverr_d = ~hit_d;
      prdata_d  = pwrite ? `RMCG_ZERO32 : rdata_d;
    end
  end

  always @(negedge presetn or posedge pclk) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RMCG_ZERO32;
    end else begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
    end
  end

  // ==========================================================
  // Gate selection by power mode
  always @* begin
    active_gate_d = run_mode_clock_gate_0_q;
    if (auto_clock_gating) begin
      case (power_mode)
        `RMCG_MODE_SLEEP: active_gate_d = sleep_mode_clock_gate_0_q;
        `RMCG_MODE_DEEP:  active_gate_d = deep_sleep_clock_gate_0_q;
        default:          active_gate_d = run_mode_clock_gate_0_q;
      endcase
    end
  end

  assign want_lpd  = active_gate_d[`RMCG_BIT_LPD];
  assign want_watchdog0_clock_gate = active_gate_d[`RMCG_BIT_WATCHDOG0_CLOCK_GATE];

  rmcg_gate_sync #(
    .RESET_ON (RUN_RESET[`RMCG_BIT_LPD])
  ) u_lpd_gate (
    .pclk     (pclk),
    .presetn  (presetn),
    .want_on  (want_lpd),
    .enable_q (lp_domain_clk_en)
  );

  rmcg_gate_sync #(
    .RESET_ON (RUN_RESET[`RMCG_BIT_WATCHDOG0_CLOCK_GATE])
  ) u_watchdog0_clock_gate_gate (
    .pclk     (pclk),
    .presetn  (presetn),
    .want_on  (want_watchdog0_clock_gate),
    .enable_q (watchdog0_clock_gate_clk_en)
  );

  // ==========================================================
  // Module access decode
  assign watchdog0_clock_gate_selected = (periph_sel == `RMCG_SEL_WATCHDOG0_CLOCK_GATE);
  assign lpd_selected  = (periph_sel == `RMCG_SEL_LPD);
  assign watchdog0_clock_gate_off      = ~watchdog0_clock_gate_clk_en;
  assign lpd_off       = ~lp_domain_clk_en;

  // ==========================================================
  // Sample rate and access fault
  always @* begin
    converter_sample_rate_d = rate_field;
    if (rate_field > max_rate) begin
      converter_sample_rate_d = max_rate;
    end
    periph_fault_d = 1'b0;
    if (periph_access & watchdog0_clock_gate_selected) begin
      periph_fault_d = watchdog0_clock_gate_off;
    end
    if (periph_access & lpd_selected) begin
      periph_fault_d = lpd_off;
    end
  end

  always @(negedge presetn or posedge pclk) begin
    if (!presetn) begin
      converter_sample_rate <= `RMCG_RATE_RESET;
      periph_fault          <= 1'b0;
    end else begin
      converter_sample_rate <= converter_sample_rate_d;
      periph_fault          <= periph_fault_d;
    end
  end
endmodule

// ### tb/rmcg_asserts.sv
// Checker of the run-mode clock gating block.
`timescale 1ns/1ps
module rmcg_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [1:0]  power_mode,
  input wire [1:0]  periph_sel,
  input wire        periph_access,
  input wire        lp_domain_clk_en,
  input wire        watchdog0_clock_gate_clk_en,
  input wire        periph_fault
);
  // ==========================================================
  // Properties.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr0 = pready && pwrite && !pslverr && paddr == 12'h100 && power_mode == 2'h0;
  a_fault_wdt: assert property (presetn && periph_access && periph_sel == 2'h1
    |=> periph_fault == !$past(watchdog0_clock_gate_clk_en)) else $error("watchdog fault wrong");
  a_fault_lp: assert property (presetn && periph_access && periph_sel == 2'h2
    |=> periph_fault == !$past(lp_domain_clk_en)) else $error("domain fault wrong");
  a_fault_idle: assert property (!periph_access || periph_sel[0] == periph_sel[1]
    |=> !periph_fault) else $error("fault without access");
  a_rsvd_zero: assert property (pready && !pwrite && !pslverr && paddr[11:8] == 4'h1
    |-> (prdata & ~32'h00000348) == 32'h00000000) else $error("reserved bit set");
  a_wdt_follow: assert property (wr0 ##2 (power_mode == 2'h0)
    |-> ##2 watchdog0_clock_gate_clk_en == $past(pwdata[3], 4))
    else $error("watchdog enable wrong");
  a_lp_follow: assert property (wr0 ##2 (power_mode == 2'h0)
    |-> ##2 lp_domain_clk_en == $past(pwdata[6], 4))
    else $error("domain enable wrong");
  a_wdt_hold: assert property ($changed(watchdog0_clock_gate_clk_en) |=> $stable(watchdog0_clock_gate_clk_en))
    else $error("watchdog enable runt");
  a_lp_hold: assert property ($changed(lp_domain_clk_en) |=> $stable(lp_domain_clk_en))
    else $error("domain enable runt");
endmodule
bind rmcg_top rmcg_asserts u_chk (.*);

// ### tb/rmcg_top_tb_top.sv
// Self-checking bench of the run-mode clock gating block.
`timescale 1ns/1ps
module rmcg_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, periph_access;
  logic        pready, pslverr, lp_domain_clk_en, watchdog0_clock_gate_clk_en, periph_fault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, w;
  logic [1:0]  power_mode, periph_sel, converter_sample_rate;
  logic [32:0] exp_q[$];
  int          failures = 0, checks = 0, cyc = 0;
  rmcg_top DUT (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .power_mode            (power_mode),
    .periph_sel            (periph_sel),
    .periph_access         (periph_access),
    .lp_domain_clk_en      (lp_domain_clk_en),
    .watchdog0_clock_gate_clk_en           (watchdog0_clock_gate_clk_en),
    .converter_sample_rate (converter_sample_rate),
    .periph_fault          (periph_fault)
  );
  // ==========================================================
  // Clock, checks and bus tasks.
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
    if (!wr) exp_q.push_back(e);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    periph_sel    <= 2'($urandom);
    periph_access <= 1'($urandom);
    if (pready === 1'h1 && psel && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
    if (cyc > 3000) begin
      failures++;
      give_verdict;
    end
  end
  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(32'hE927));
    {presetn, psel, penable, pwrite, paddr, pwdata} = 'h0;
    power_mode = 2'h0;
    repeat (3) @(posedge pclk);
    check({lp_domain_clk_en, watchdog0_clock_gate_clk_en}, 2'h2);
    presetn <= 1'h1;
    @(posedge pclk);
    xfer(1'h0, 12'h100, 32'h0, {1'h0, 32'h00000040});
    check({lp_domain_clk_en, watchdog0_clock_gate_clk_en}, 2'h2);
    xfer(1'h1, 12'h060, 32'h00000006, 33'h0);
    for (int r = 0; r < 4; r++) begin
      w = $urandom;
      w[9:8] = 2'(r);
      xfer(1'h1, 12'h100, w, 33'h0);
      xfer(1'h0, 12'h100, 32'h0, {1'h0, w & 32'h00000348});
      check({lp_domain_clk_en, watchdog0_clock_gate_clk_en, converter_sample_rate}, {w[6], w[3], w[9:8]});
    end
    xfer(1'h1, 12'h060, 32'h00000002, 33'h0);
    repeat (2) @(posedge pclk);
    check(converter_sample_rate, 2'h1);
    xfer(1'h0, 12'h004, 32'h0, {1'h1, 32'h0});
    xfer(1'h1, 12'h100, 32'h0, 33'h0);
    xfer(1'h1, 12'h110, 32'h00000048, 33'h0);
    xfer(1'h1, 12'h120, 32'h00000008, 33'h0);
    xfer(1'h1, 12'h060, 32'h00000001, 33'h0);
    power_mode <= 2'h1;
    repeat (5) @(posedge pclk);
    check({lp_domain_clk_en, watchdog0_clock_gate_clk_en}, 2'h3);
    power_mode <= 2'h2;
    repeat (5) @(posedge pclk);
    check({lp_domain_clk_en, watchdog0_clock_gate_clk_en}, 2'h1);
    power_mode <= 2'h0;
    repeat (5) @(posedge pclk);
    check({lp_domain_clk_en, watchdog0_clock_gate_clk_en}, 2'h0);
    give_verdict;
  end
endmodule
